// ---- hw/ptp_regs.svh ----
// Purpose: Register map and constants of the pulse-train position front end
// Assumes: AXI4-Lite, 32-bit words, byte addresses
// Notes: Offsets are word aligned
`ifndef PTP_REGS_SVH
`define PTP_REGS_SVH
`define PTP_OFS_MODE 5'h00
`define PTP_OFS_REFCFG 5'h04
`define PTP_OFS_GEAR 5'h08
`define PTP_OFS_STATUS 5'h0c
`define PTP_OFS_ERROR 5'h10
`define PTP_OFS_FBPOS 5'h14
`define PTP_MODE_POSITION 4'h1
`define PTP_CLR_HIGH 2'h0
`define PTP_CLR_RISE 2'h1
`define PTP_CLR_LOW 2'h2
`define PTP_CLR_FALL 2'h3
`define PTP_AUTO_BASEBLOCK 2'h0
`define PTP_AUTO_NONE 2'h1
`define PTP_AUTO_ALARM 2'h2
`define PTP_FORM_SIGN_PULSE 4'h0
`define PTP_FORM_CW_CCW 4'h1
`define PTP_GEAR_NUM_RST 16'h0004
`define PTP_GEAR_DEN_RST 16'h0001
`define PTP_FB_FRAC_BITS 8
`define PTP_RESP_OKAY 2'h0
`define PTP_RESP_SLVERR 2'h2
`endif

// ---- hw/ptp_pkg.sv ----
// Purpose: Types of the pulse-train position front end
// Assumes: ptp_regs.svh constants
// Notes: All block state is one packed struct
package ptp_pkg;
   typedef struct packed {
      logic [4:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [4:0] araddr;
      logic arvalid;
      logic rready;
   } ptp_axi_in_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } ptp_axi_out_t;
   typedef struct packed {
      logic ref_pulse_in;
      logic ref_sign_in;
      logic error_clear_in;
      logic servo_on_cmd;
      logic main_power_ok;
      logic alarm_active;
      logic fb_up;
      logic fb_down;
   } ptp_pins_t;
   typedef struct packed {
      ptp_axi_out_t axi;
      logic [3:0] control_mode_param;
      logic [3:0] ref_pulse_form_sel;
      logic [1:0] clear_signal_form_sel;
      logic [1:0] auto_clear_mode_sel;
      logic [15:0] gear_numerator;
      logic [15:0] gear_denominator;
      logic [15:0] num_pend;
      logic [15:0] den_pend;
      logic [15:0] gear_acc;
      logic [31:0] pos_error;
      logic [31:0] fb_pos;
      logic aw_held;
      logic w_held;
      logic [4:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic pulse_d;
      logic clr_d;
      logic clr_active;
      logic loop_enable;
      logic gear_rev;
   } ptp_state_t;
endpackage : ptp_pkg

// ---- hw/ptp_core.sv ----
// Purpose: Pulse-train position input, gear scaling and position error counter
// Assumes: All pin inputs synchronous to ref_clk; AXI4-Lite slave for setup
// Notes: Gear values written by software apply only on the restart command
// Notes on behaviour
// - Position control from pulse train only when control mode digit equals 1.
// - Pulse and sign inputs decoded by the selected input form.
// - Clear mode 0 clears continuously while clear input is high.
// - Clear mode 1 clears once on each rising clear edge.
// - Clear mode 2 clears continuously while clear input is low.
// - Clear mode 3 clears once on each falling clear edge.
// - Any clear forces the position error counter to zero.
// - Position loop is disabled while a clear is in effect.
// - Unconnected clear input reads low and never clears in mode 0.
// - Auto-clear mode 0 also clears during baseblock: servo off, power off, alarm.
// - Auto-clear mode 1 never clears automatically, only by clear input.
// - Auto-clear mode 2 also clears automatically while an alarm is present.
// - Feedback position is held in units of 1/256 scale pitch.
// - Each reference pulse is scaled by numerator over denominator.
// - Numerator range 1..65535, default 4, applied at restart.
// - Denominator range 1..65535, default 1, applied at restart.
// - In sign-plus-pulse form, sign high is forward, low is reverse.
`timescale 1ns/10ps
`default_nettype none
`include "ptp_regs.svh"
module ptp_core (
   input wire logic ref_clk,
   input wire logic rst,
   input wire ptp_pkg::ptp_axi_in_t axi_in,
   output var ptp_pkg::ptp_axi_out_t axi_out,
   input wire ptp_pkg::ptp_pins_t pins,
   input wire logic restart_cmd,
   output logic [31:0] pos_error,
   output logic loop_enable
);
   import ptp_pkg::*;

   ptp_state_t s_r;
   ptp_state_t s_nxt;
   logic pulse_rise;
   logic step_fwd;
   logic step_rev;
   logic [16:0] acc_sum;
   logic [31:0] gear_steps;
   logic step_dir_rev;
   logic clr_edge_rise;
   logic clr_edge_fall;
   logic clr_by_pin;
   logic clr_auto;
   logic clr_now;
   logic pos_mode;
   logic do_write;
   logic [31:0] rd_word;

   // ----------------------------------------------------------------
   // Reference pulse decode and gear
   // ----------------------------------------------------------------
   always_comb begin
      pos_mode = (s_r.control_mode_param == `PTP_MODE_POSITION);
      pulse_rise = pins.ref_pulse_in & ~s_r.pulse_d;
      step_fwd = 1'b0;
      step_rev = 1'b0;
      if (pos_mode && pulse_rise) begin
         if (s_r.ref_pulse_form_sel == `PTP_FORM_CW_CCW) begin
            // Sign line level sets direction in this form: high counts reverse, low counts forward
            step_fwd = ~pins.ref_sign_in;
            step_rev = pins.ref_sign_in;
         end else begin
            step_fwd = pins.ref_sign_in;
            step_rev = ~pins.ref_sign_in;
         end
      end
      // Bresenham style division: remainder accumulates so no count is lost
      acc_sum = {1'b0, s_r.gear_acc};
      if (step_fwd || step_rev) begin
         acc_sum = {1'b0, s_r.gear_acc} + {1'b0, s_r.gear_numerator};
      end
   end

   // ----------------------------------------------------------------
   // Clear selection
   // ----------------------------------------------------------------
   always_comb begin
      clr_edge_rise = pins.error_clear_in & ~s_r.clr_d;
      clr_edge_fall = ~pins.error_clear_in & s_r.clr_d;
      unique case (s_r.clear_signal_form_sel)
         `PTP_CLR_HIGH: clr_by_pin = pins.error_clear_in;
         `PTP_CLR_RISE: clr_by_pin = clr_edge_rise;
         `PTP_CLR_LOW: clr_by_pin = ~pins.error_clear_in;
         `PTP_CLR_FALL: clr_by_pin = clr_edge_fall;
      endcase
      unique case (s_r.auto_clear_mode_sel)
         `PTP_AUTO_BASEBLOCK: clr_auto = ~pins.servo_on_cmd | ~pins.main_power_ok | pins.alarm_active;
         `PTP_AUTO_NONE: clr_auto = 1'b0;
         `PTP_AUTO_ALARM: clr_auto = pins.alarm_active;
         default: clr_auto = 1'b0;
      endcase
      clr_now = clr_by_pin | clr_auto;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      gear_steps = 32'h0;
      // Trailing gear steps keep the direction of the pulse that produced them
      step_dir_rev = (step_fwd || step_rev) ? step_rev : s_r.gear_rev;
      s_nxt.gear_rev = step_dir_rev;
      s_nxt.pulse_d = pins.ref_pulse_in;
      s_nxt.clr_d = pins.error_clear_in;
      s_nxt.clr_active = clr_now;
      s_nxt.loop_enable = pos_mode & ~clr_now;
      // One step of the division per clock; input pulses are far slower
      if (acc_sum >= {1'b0, s_r.gear_denominator}) begin
         s_nxt.gear_acc = 16'(acc_sum - {1'b0, s_r.gear_denominator});
         gear_steps = 32'h1;
      end else begin
         s_nxt.gear_acc = acc_sum[15:0];
      end
      if (pins.fb_up) begin
         s_nxt.fb_pos = s_r.fb_pos + 32'h1;
      end else if (pins.fb_down) begin
         s_nxt.fb_pos = s_r.fb_pos - 32'h1;
      end
      begin
         logic [31:0] e;
         e = s_r.pos_error;
         if (step_dir_rev) begin
            e = e - gear_steps;
         end else begin
            e = e + gear_steps;
         end
         if (pins.fb_up) begin
            e = e - 32'h1;
         end else if (pins.fb_down) begin
            e = e + 32'h1;
         end
         s_nxt.pos_error = clr_now ? 32'h0 : e;
         if (clr_now) begin
            s_nxt.gear_acc = 16'h0;
         end
      end
      if (restart_cmd) begin
         s_nxt.gear_numerator = s_r.num_pend;
         s_nxt.gear_denominator = s_r.den_pend;
         s_nxt.gear_acc = 16'h0;
      end

      // AXI4-Lite write
      if (s_r.axi.awready && axi_in.awvalid) begin
         s_nxt.aw_held = 1'b1;
         s_nxt.aw_addr = axi_in.awaddr;
         s_nxt.axi.awready = 1'b0;
      end
      if (s_r.axi.wready && axi_in.wvalid) begin
         s_nxt.w_held = 1'b1;
         s_nxt.w_data = axi_in.wdata;
         s_nxt.w_strb = axi_in.wstrb;
         s_nxt.axi.wready = 1'b0;
      end
      do_write = s_r.aw_held && s_r.w_held && !s_r.axi.bvalid;
      if (do_write) begin
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held = 1'b0;
         s_nxt.axi.bvalid = 1'b1;
         s_nxt.axi.bresp = `PTP_RESP_OKAY;
         unique case (s_r.aw_addr)
            `PTP_OFS_MODE: begin
               if (s_r.w_strb[0]) begin
                  s_nxt.control_mode_param = s_r.w_data[3:0];
               end
            end
            `PTP_OFS_REFCFG: begin
               if (s_r.w_strb[0]) begin
                  s_nxt.ref_pulse_form_sel = s_r.w_data[3:0];
                  s_nxt.clear_signal_form_sel = s_r.w_data[5:4];
               end
               if (s_r.w_strb[1]) begin
                  s_nxt.auto_clear_mode_sel = s_r.w_data[9:8];
               end
            end
            `PTP_OFS_GEAR: begin
               // Zero is outside the range and is refused as an error
               if (s_r.w_data[15:0] == 16'h0 || s_r.w_data[31:16] == 16'h0) begin
                  s_nxt.axi.bresp = `PTP_RESP_SLVERR;
               end else begin
                  s_nxt.num_pend = s_r.w_data[15:0];
                  s_nxt.den_pend = s_r.w_data[31:16];
               end
            end
            default: s_nxt.axi.bresp = `PTP_RESP_SLVERR;
         endcase
      end
      if (s_r.axi.bvalid && axi_in.bready) begin
         s_nxt.axi.bvalid = 1'b0;
         s_nxt.axi.awready = 1'b1;
         s_nxt.axi.wready = 1'b1;
      end

      // AXI4-Lite read
      rd_word = 32'h0;
      unique case (axi_in.araddr)
         `PTP_OFS_MODE: rd_word = {28'h0, s_r.control_mode_param};
         `PTP_OFS_REFCFG: rd_word = {22'h0, s_r.auto_clear_mode_sel, 2'h0, s_r.clear_signal_form_sel,
                                     s_r.ref_pulse_form_sel};
         `PTP_OFS_GEAR: rd_word = {s_r.gear_denominator, s_r.gear_numerator};
         `PTP_OFS_STATUS: rd_word = {30'h0, s_r.loop_enable, s_r.clr_active};
         `PTP_OFS_ERROR: rd_word = s_r.pos_error;
         `PTP_OFS_FBPOS: rd_word = s_r.fb_pos;
         default: rd_word = 32'h0;
      endcase
      if (s_r.axi.arready && axi_in.arvalid) begin
         s_nxt.axi.arready = 1'b0;
         s_nxt.axi.rvalid = 1'b1;
         s_nxt.axi.rdata = rd_word;
         s_nxt.axi.rresp = (axi_in.araddr > `PTP_OFS_FBPOS || axi_in.araddr[1:0] != 2'h0) ?
                           `PTP_RESP_SLVERR : `PTP_RESP_OKAY;
      end
      if (s_r.axi.rvalid && axi_in.rready) begin
         s_nxt.axi.rvalid = 1'b0;
         s_nxt.axi.arready = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.axi.awready <= 1'b1;
         s_r.axi.wready <= 1'b1;
         s_r.axi.arready <= 1'b1;
         s_r.gear_numerator <= `PTP_GEAR_NUM_RST;
         s_r.gear_denominator <= `PTP_GEAR_DEN_RST;
         s_r.num_pend <= `PTP_GEAR_NUM_RST;
         s_r.den_pend <= `PTP_GEAR_DEN_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_comb begin
      axi_out = s_r.axi;
      pos_error = s_r.pos_error;
      loop_enable = s_r.loop_enable;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_clear_zeroes_error: assert property (@(posedge ref_clk) disable iff (rst)
      clr_now |=> (s_r.pos_error == 32'h0)) else $error("error not zero after clear");
   a_clear_stops_loop: assert property (@(posedge ref_clk) disable iff (rst)
      clr_now |=> !loop_enable) else $error("loop enabled during clear");
   a_high_level_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.clear_signal_form_sel == `PTP_CLR_HIGH && pins.error_clear_in) |-> clr_now)
      else $error("high level clear missed");
   a_rise_once_only: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.clear_signal_form_sel == `PTP_CLR_RISE && $past(pins.error_clear_in) && pins.error_clear_in)
      |-> !clr_by_pin) else $error("rising mode cleared while held");
   a_low_level_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.clear_signal_form_sel == `PTP_CLR_LOW && !pins.error_clear_in) |-> clr_now)
      else $error("low level clear missed");
   a_fall_edge_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.clear_signal_form_sel == `PTP_CLR_FALL && $fell(pins.error_clear_in)) |-> clr_now)
      else $error("falling edge clear missed");
   a_no_auto_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.auto_clear_mode_sel == `PTP_AUTO_NONE && !clr_by_pin) |=> s_r.loop_enable == $past(pos_mode))
      else $error("automatic clear in mode 1");
   a_alarm_clears: assert property (@(posedge ref_clk) disable iff (rst)
      ((s_r.auto_clear_mode_sel == `PTP_AUTO_BASEBLOCK || s_r.auto_clear_mode_sel == `PTP_AUTO_ALARM)
       && pins.alarm_active) |=> pos_error == 32'h0)
      else $error("alarm did not clear error");
   a_mode_gates_loop: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.control_mode_param != `PTP_MODE_POSITION) |=> !loop_enable) else $error("loop without mode 1");
   a_gear_on_restart: assert property (@(posedge ref_clk) disable iff (rst)
      !restart_cmd |=> $stable(s_r.gear_numerator) && $stable(s_r.gear_denominator))
      else $error("gear changed without restart");
endmodule : ptp_core
`default_nettype wire

// ---- testbench/ptp_host_model.sv ----
// Purpose: Host controller model sending reference pulse trains
// Assumes: ref_clk domain, one train at a time
// Notes: Pulse stays high and low for gap cycles each
`timescale 1ns/10ps
`default_nettype none
module ptp_host_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic go,
   input wire logic dir,
   input wire logic [7:0] count,
   input wire logic [7:0] gap,
   output logic pulse,
   output logic sign,
   output logic busy
);
   logic [7:0] left_r;
   logic [7:0] tick_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         left_r <= 8'h00;
         tick_r <= 8'h00;
         pulse <= 1'b0;
         sign <= 1'b0;
         busy <= 1'b0;
      end else if (go && !busy) begin
         // Sign settles a full gap before the first rising edge
         sign <= dir;
         left_r <= count;
         tick_r <= 8'h00;
         busy <= 1'b1;
      end else if (busy) begin
         tick_r <= tick_r + 8'h01;
         if (tick_r == gap - 8'h01) begin
            tick_r <= 8'h00;
            pulse <= !pulse;
            if (pulse) begin
               left_r <= left_r - 8'h01;
               busy <= (left_r != 8'h01);
            end
         end
      end
   end
endmodule : ptp_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench of the pulse-train position front end
// Assumes: AXI4-Lite with bready and rready held high
// Notes: Expected error counts follow gear and clear settings
`timescale 1ns/10ps
`default_nettype none
`include "ptp_regs.svh"
module tb_top;
   import ptp_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   ptp_axi_in_t ai;
   ptp_axi_out_t ao;
   ptp_pins_t pins;
   logic restart = 1'b0;
   logic [31:0] pos_error;
   logic loop_enable;
   logic go = 1'b0;
   logic dir = 1'b0;
   logic [7:0] count = 8'h00;
   logic [7:0] gap = 8'h04;
   logic pulse_w, sign_w, busy;
   logic clr = 1'b0, son = 1'b1, pok = 1'b1, alm = 1'b0, fbu = 1'b0, fbd = 1'b0;
   int bad_count = 0;
   int samples_checked = 0;
   int exp_err = 0;
   assign pins = {pulse_w, sign_w, clr, son, pok, alm, fbu, fbd};
   always #12.5 ref_clk = ~ref_clk;
   ptp_core dut (.ref_clk(ref_clk), .rst(rst), .axi_in(ai), .axi_out(ao), .pins(pins),
      .restart_cmd(restart), .pos_error(pos_error), .loop_enable(loop_enable));
   ptp_host_model host (.ref_clk(ref_clk), .rst(rst), .go(go), .dir(dir), .count(count),
      .gap(gap), .pulse(pulse_w), .sign(sign_w), .busy(busy));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      ai.awaddr <= a;
      ai.wdata <= d;
      ai.wstrb <= 4'hf;
      ai.awvalid <= 1'b1;
      ai.wvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (ai.awvalid && ao.awready) ai.awvalid <= 1'b0;
         if (ai.wvalid && ao.wready) ai.wvalid <= 1'b0;
      end while (!ao.bvalid);
      chk({30'h0, ao.bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      ai.araddr <= a;
      ai.arvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (ai.arvalid && ao.arready) ai.arvalid <= 1'b0;
      end while (!ao.rvalid);
      chk(ao.rdata, d);
      chk({30'h0, ao.rresp}, {30'h0, er});
   endtask : rd
   task automatic send(input logic d, input logic [7:0] c, input logic [7:0] g);
      int n;
      n = 0;
      dir <= d;
      count <= c;
      gap <= g;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (busy && n < 5000);
      // Gear steps trail the last pulse by up to ratio cycles
      cyc(4);
   endtask : send
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(`PTP_OFS_MODE, 32'h0, `PTP_RESP_OKAY);
      rd(`PTP_OFS_GEAR, 32'h0001_0004, `PTP_RESP_OKAY);
      rd(5'h18, 32'h0, `PTP_RESP_SLVERR);
      chk(loop_enable, 1'b0);
   endtask : t_reset
   task automatic t_count();
      wr(`PTP_OFS_MODE, 32'h1, `PTP_RESP_OKAY);
      cyc(2);
      chk(loop_enable, 1'b1);
      send(1'b1, 8'd3, 8'd4);
      chk(pos_error, 32'd12);
      send(1'b0, 8'd2, 8'd4);
      chk(pos_error, 32'd4);
      repeat (2) begin
         fbu <= 1'b1;
         cyc(1);
         fbu <= 1'b0;
         cyc(1);
      end
      fbd <= 1'b1;
      cyc(1);
      fbd <= 1'b0;
      cyc(2);
      exp_err = 3;
      chk(pos_error, exp_err);
      wr(`PTP_OFS_MODE, 32'h2, `PTP_RESP_OKAY);
      cyc(2);
      chk(loop_enable, 1'b0);
      wr(`PTP_OFS_MODE, 32'h1, `PTP_RESP_OKAY);
      // Second form takes a low sign as a forward count
      wr(`PTP_OFS_REFCFG, 32'h1, `PTP_RESP_OKAY);
      send(1'b0, 8'd1, 8'd4);
      exp_err += 4;
      chk(pos_error, exp_err);
      wr(`PTP_OFS_REFCFG, 32'h0, `PTP_RESP_OKAY);
   endtask : t_count
   task automatic t_clear();
      for (int m = 0; m < 4; m++) begin
         clr <= (m >= 2);
         cyc(3);
         wr(`PTP_OFS_REFCFG, 32'h100 | (m << 4), `PTP_RESP_OKAY);
         if (m == 2) exp_err = 0;
         send(1'b1, 8'd2, 8'd4);
         exp_err += 8;
         chk(pos_error, exp_err);
         clr <= (m < 2);
         cyc(3);
         send(1'b1, 8'd1, 8'd4);
         exp_err = (m % 2) ? 4 : 0;
         chk(pos_error, exp_err);
         chk(loop_enable, m % 2);
         cyc(790);
         clr <= (m >= 2);
         cyc(3);
      end
   endtask : t_clear
   task automatic t_auto();
      clr <= 1'b0;
      cyc(3);
      exp_err = 0;
      for (int a = 0; a < 3; a++) begin
         wr(`PTP_OFS_REFCFG, a << 8, `PTP_RESP_OKAY);
         for (int c = 0; c < 3; c++) begin
            send(1'b1, 8'd1, 8'd4);
            exp_err += 4;
            son <= (c != 0);
            pok <= (c != 1);
            alm <= (c == 2);
            cyc(4);
            if (a == 0 || (a == 2 && c == 2)) exp_err = 0;
            chk(pos_error, exp_err);
            son <= 1'b1;
            pok <= 1'b1;
            alm <= 1'b0;
            cyc(2);
         end
      end
   endtask : t_auto
   task automatic t_gear();
      wr(`PTP_OFS_GEAR, 32'h0014_0100, `PTP_RESP_OKAY);
      wr(`PTP_OFS_GEAR, 32'h0000_0005, `PTP_RESP_SLVERR);
      wr(`PTP_OFS_STATUS, 32'h1, `PTP_RESP_SLVERR);
      rd(`PTP_OFS_GEAR, 32'h0001_0004, `PTP_RESP_OKAY);
      restart <= 1'b1;
      cyc(1);
      restart <= 1'b0;
      cyc(1);
      rd(`PTP_OFS_GEAR, 32'h0014_0100, `PTP_RESP_OKAY);
      send(1'b1, 8'd5, 8'd16);
      exp_err += 64;
      chk(pos_error, exp_err);
   endtask : t_gear
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      ai = '0;
      ai.bready = 1'b1;
      ai.rready = 1'b1;
      cyc(4);
      rst <= 1'b0;
      t_reset();
      t_count();
      t_clear();
      t_auto();
      t_gear();
      tally_and_finish();
   end
   initial begin
      cyc(60000);
      bad_count++;
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
